/* File: logic/pwtb_chan.sv */
// pwtb_chan: one pwm output with single-pulse latch and manual override
`default_nettype none

module pwtb_chan (
    // clock and reset
    input  wire logic                            core_clk_i,
    input  wire logic                            resetn_i,
    // time base
    input  wire logic [pwtb_pkg::PWTB_CNT_W-1:0] cnt_i,
    input  wire logic [pwtb_pkg::PWTB_CNT_W-1:0] duty_i,
    input  wire logic                            run_i,
    input  wire logic                            single_i,
    input  wire logic                            start_i,
    input  wire logic                            stop_i,
    // override
    input  wire logic                            ovd_en_i,
    input  wire logic                            ovd_lvl_i,
    // pin
    output logic                                 pwm_o
);
    import pwtb_pkg::*;

    typedef struct packed {
        logic pulse;
        logic pwm;
    } pwtb_chan_s;

    pwtb_chan_s st_q;
    pwtb_chan_s st_d;
    logic       raw;

    always_comb begin
        st_d = st_q;
        if (start_i) begin
            st_d.pulse = 1'b1;
        end else if (stop_i) begin
            st_d.pulse = 1'b0;
        end else if (cnt_i == duty_i) begin
            st_d.pulse = 1'b0;
        end
        // edge and centre modes compare the count against duty
        raw = single_i ? st_q.pulse : (run_i && (cnt_i < duty_i));
        st_d.pwm = ovd_en_i ? raw : ovd_lvl_i;
    end

    assign pwm_o = st_q.pwm;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    property p_ovd_force;
        @(posedge core_clk_i) disable iff (!resetn_i)
        !ovd_en_i |=> (pwm_o == $past(ovd_lvl_i));
    endproperty
    a_ovd_force: assert property (p_ovd_force) else $error("override level not on pin");

    property p_duty_drop;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (!start_i && st_q.pulse && cnt_i == duty_i) |=> !st_q.pulse;
    endproperty
    a_duty_drop: assert property (p_duty_drop) else $error("pulse not ended at duty");

    property p_start_high;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (start_i && single_i && ovd_en_i) |=> ##1 pwm_o;
    endproperty
    a_start_high: assert property (p_start_high) else $error("pulse did not start");

endmodule : pwtb_chan

`default_nettype wire

/* File: logic/pwtb_div.sv */
// pwtb_div: clearable enable divider, one tick per limit+1 enables
`default_nettype none

module pwtb_div #(
    parameter int unsigned W = 6
) (
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         resetn_i,
    // control
    input  wire logic         en_i,
    input  wire logic         clr_i,
    input  wire logic [W-1:0] lim_i,
    // result
    output logic              tick_o
);
    import pwtb_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
    } pwtb_div_s;

    pwtb_div_s st_q;
    pwtb_div_s st_d;

    // tick on the enable that reaches the limit; clear drops any pending count
    assign tick_o = en_i && !clr_i && (st_q.cnt >= lim_i);

    always_comb begin
        st_d = st_q;
        if (clr_i) begin
            st_d.cnt = '0;
        end else if (tick_o) begin
            st_d.cnt = '0;
        end else if (en_i) begin
            st_d.cnt = st_q.cnt + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    property p_clr_zero;
        @(posedge core_clk_i) disable iff (!resetn_i)
        clr_i |=> (st_q.cnt == '0);
    endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("divider count not cleared");

endmodule : pwtb_div

`default_nettype wire

/* File: logic/pwtb_timebase.sv */
// pwtb_timebase: 12-bit pwm time base with prescaler, postscaler and single pulse
//
// Operation
// - counter ticks fosc/4 through 1/4/16/64 prescaler
// - prescaler cleared by counter, control writes, reset
// - control write keeps counter value
// - 4-bit postscaler divides match interrupts
// - postscaler cleared by counter, control writes, reset
// - free-running: interrupt per match, then zero
// - period from 4 high and 8 low bits
// - edge modes load period at wrap
// - up/down modes load period at zero
// - stopped time base loads period continuously
// - free-running period is (period+1) times prescale
// - up/down period is twice period times prescale
// - override chooses pwm, inactive or active
// - mode 01 selects edge-aligned single pulse
// - run set drives enabled pins active
// - duty match drives channel inactive
// - period match ends pulse, stops, interrupts
// - period and duty kept after pulse
// - free-running counts up, wraps, keeps running
// - single shot clears run after match
// - up/down reverses after match, direction readable
`default_nettype none

module pwtb_timebase (
    // clock and reset
    input  wire logic                                                core_clk_i,
    input  wire logic                                                resetn_i,
    // time-base control registers
    input  wire logic                                                ctl_wr_i,
    input  wire pwtb_pkg::pwtb_ctl_s                                 ctl_i,
    input  wire logic                                                run_set_i,
    input  wire logic                                                run_clr_i,
    // counter and period writes
    input  wire logic                                                cnt_wr_i,
    input  wire logic [pwtb_pkg::PWTB_CNT_W-1:0]                     cnt_data_i,
    input  wire logic                                                per_lo_wr_i,
    input  wire logic                                                per_hi_wr_i,
    input  wire logic [7:0]                                          per_byte_i,
    // duty and override
    input  wire logic [pwtb_pkg::PWTB_NCH-1:0][pwtb_pkg::PWTB_CNT_W-1:0] duty_value_i,
    input  wire logic [pwtb_pkg::PWTB_NCH-1:0]                       override_enable_mask_i,
    input  wire logic [pwtb_pkg::PWTB_NCH-1:0]                       override_level_select_i,
    // status
    output logic [pwtb_pkg::PWTB_CNT_W-1:0]                          timebase_counter_o,
    output logic [pwtb_pkg::PWTB_CNT_W-1:0]                          period_value_o,
    output logic                                                     timebase_run_bit_o,
    output logic                                                     count_direction_flag_o,
    output logic                                                     timebase_irq_o,
    // pins
    output logic [pwtb_pkg::PWTB_NCH-1:0]                            pwm_o
);
    import pwtb_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        pwtb_ctl_s             ctl;
        logic [PWTB_CNT_W-1:0] cnt;
        logic [PWTB_CNT_W-1:0] per_act;
        logic [PWTB_CNT_W-1:0] per_buf;
        logic                  run;
        logic                  dir;
        logic                  irq;
    } pwtb_tb_s;

    localparam pwtb_tb_s PWTB_TB_RST = '0;

    pwtb_tb_s st_q;
    pwtb_tb_s st_d;

    logic icyc_tick;
    logic pre_tick;
    logic post_tick;
    logic scl_clr;
    logic match;
    logic match_evt;
    logic updown;
    logic single;
    logic single_end;
    logic start;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    // upper codes count up/down
    assign updown = st_q.ctl.timebase_mode_select inside {PWTB_MODE_UPDOWN, PWTB_MODE_UPDOWN_ALT};
    assign single = (st_q.ctl.timebase_mode_select == PWTB_MODE_SINGLE);
    assign match  = (st_q.cnt == st_q.per_act);

    assign scl_clr = cnt_wr_i || ctl_wr_i;

    // match only counts on the way up; a centre count hits the period once per cycle
    assign match_evt  = pre_tick && match && !st_q.dir && !cnt_wr_i;
    assign single_end = match_evt && single;
    // pulse starts on the rising run bit
    assign start      = run_set_i && !st_q.run && single;

    // ------------------------------------------------------------------
    // clock dividers
    // ------------------------------------------------------------------
    // instruction clock is fosc/4, free running
    pwtb_div #(
        .W (PWTB_DIV_W)
    ) u_icyc (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .en_i       (1'b1),
        .clr_i      (1'b0),
        .lim_i      (PWTB_ICYC_LIM),
        .tick_o     (icyc_tick)
    );

    pwtb_div #(
        .W (PWTB_DIV_W)
    ) u_pre (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .en_i       (icyc_tick && st_q.run),
        .clr_i      (scl_clr),
        .lim_i      (pwtb_pre_lim(st_q.ctl.prescale_select)),
        .tick_o     (pre_tick)
    );

    pwtb_div #(
        .W (PWTB_DIV_W)
    ) u_post (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .en_i       (match_evt),
        .clr_i      (scl_clr),
        .lim_i      ({2'b00, st_q.ctl.postscale_select}),
        .tick_o     (post_tick)
    );

    // ------------------------------------------------------------------
    // counter, period and run bit
    // ------------------------------------------------------------------
    always_comb begin
        st_d     = st_q;
        st_d.irq = post_tick;
        if (ctl_wr_i) begin
            st_d.ctl = ctl_i;
        end
        if (per_lo_wr_i) begin
            st_d.per_buf[PWTB_PER_HI_LSB-1:0] = per_byte_i;
        end
        if (per_hi_wr_i) begin
            st_d.per_buf[PWTB_CNT_W-1:PWTB_PER_HI_LSB] = per_byte_i[PWTB_PER_HI_W-1:0];
        end
        if (cnt_wr_i) begin
            st_d.cnt = cnt_data_i;
        end else if (pre_tick) begin
            if (!updown) begin
                st_d.dir = 1'b0;
                if (match) begin
                    st_d.cnt     = PWTB_CNT_ZERO;
                    st_d.per_act = st_q.per_buf;
                end else begin
                    st_d.cnt = st_q.cnt + PWTB_CNT_ONE;
                end
            end else if (!st_q.dir) begin
                if (match) begin
                    st_d.dir = 1'b1;
                    st_d.cnt = (st_q.per_act == PWTB_CNT_ZERO) ? PWTB_CNT_ZERO : st_q.per_act - PWTB_CNT_ONE;
                end else begin
                    st_d.cnt = st_q.cnt + PWTB_CNT_ONE;
                end
            // down leg mirrors the up leg
            end else if (st_q.cnt == PWTB_CNT_ZERO) begin
                st_d.dir = 1'b0;
                // a zero period parks the count at zero instead of running off upwards
                st_d.cnt = (st_q.per_act == PWTB_CNT_ZERO) ? PWTB_CNT_ZERO : PWTB_CNT_ONE;
            end else begin
                st_d.cnt = st_q.cnt - PWTB_CNT_ONE;
            end
        end
        if (updown && st_q.cnt == PWTB_CNT_ZERO) begin
            st_d.per_act = st_q.per_buf;
        end
        if (!st_q.run) begin
            st_d.per_act = st_q.per_buf;
        end
        // software set wins over the hardware stop in the same cycle
        if (run_set_i) begin
            st_d.run = 1'b1;
        end else if (run_clr_i) begin
            st_d.run = 1'b0;
        end else if (single_end) begin
            st_d.run = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= PWTB_TB_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // interrupt after postscale
    assign timebase_irq_o         = st_q.irq;
    assign timebase_counter_o     = st_q.cnt;
    assign period_value_o         = st_q.per_act;
    assign timebase_run_bit_o     = st_q.run;
    assign count_direction_flag_o = st_q.dir;

    // duty and period untouched by pulse end
    for (genvar ch = 0; ch < PWTB_NCH; ch++) begin : g_ch
        pwtb_chan u_chan (
            .core_clk_i (core_clk_i),
            .resetn_i   (resetn_i),
            .cnt_i      (st_q.cnt),
            .duty_i     (duty_value_i[ch]),
            .run_i      (st_q.run),
            .single_i   (single),
            .start_i    (start),
            .stop_i     (single_end),
            .ovd_en_i   (override_enable_mask_i[ch]),
            .ovd_lvl_i  (override_level_select_i[ch]),
            .pwm_o      (pwm_o[ch])
        );
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    property p_ctl_keep;
        (ctl_wr_i && !cnt_wr_i && !pre_tick) |=> (st_q.cnt == $past(st_q.cnt));
    endproperty
    a_ctl_keep: assert property (p_ctl_keep) else $error("control write moved counter");

    property p_free_wrap;
        (pre_tick && !cnt_wr_i && !updown && match) |=> (st_q.cnt == PWTB_CNT_ZERO);
    endproperty
    a_free_wrap: assert property (p_free_wrap) else $error("counter did not wrap at period");

    property p_wrap_load;
        (pre_tick && !cnt_wr_i && !updown && match) |=> (st_q.per_act == $past(st_q.per_buf));
    endproperty
    a_wrap_load: assert property (p_wrap_load) else $error("period not loaded at wrap");

    property p_idle_load;
        !st_q.run |=> (st_q.per_act == $past(st_q.per_buf));
    endproperty
    a_idle_load: assert property (p_idle_load) else $error("idle period not tracking buffer");

    property p_single_stop;
        (single_end && !run_set_i && !run_clr_i) |=> !st_q.run && st_q.cnt == PWTB_CNT_ZERO;
    endproperty
    a_single_stop: assert property (p_single_stop) else $error("single pulse did not stop");

    property p_reverse;
        (pre_tick && !cnt_wr_i && updown && !st_q.dir && match && st_q.per_act != PWTB_CNT_ZERO)
            |=> st_q.dir && (st_q.cnt == $past(st_q.per_act) - PWTB_CNT_ONE);
    endproperty
    a_reverse: assert property (p_reverse) else $error("no reversal after match");

    property p_ud_load;
        (updown && st_q.cnt == PWTB_CNT_ZERO) |=> (st_q.per_act == $past(st_q.per_buf));
    endproperty
    a_ud_load: assert property (p_ud_load) else $error("period not loaded at zero");

    property p_irq_src;
        timebase_irq_o |-> $past(match_evt);
    endproperty
    a_irq_src: assert property (p_irq_src) else $error("interrupt without match");

endmodule : pwtb_timebase

`default_nettype wire

/* File: pkg/pwtb_pkg.sv */
// pwtb_pkg: shared constants and types of the pwm time base
`default_nettype none

package pwtb_pkg;

    // ------------------------------------------------------------------
    // widths and sizes
    // ------------------------------------------------------------------
    localparam int unsigned PWTB_CNT_W = 12;
    localparam int unsigned PWTB_NCH   = 6;
    localparam int unsigned PWTB_DIV_W = 6;

    // ------------------------------------------------------------------
    // divider limits (terminal count = ratio - 1)
    // ------------------------------------------------------------------
    localparam logic [PWTB_DIV_W-1:0] PWTB_ICYC_LIM  = 6'h03;   // fosc/4
    localparam logic [PWTB_DIV_W-1:0] PWTB_PRE1_LIM  = 6'h00;   // 1:1
    localparam logic [PWTB_DIV_W-1:0] PWTB_PRE4_LIM  = 6'h03;   // 1:4
    localparam logic [PWTB_DIV_W-1:0] PWTB_PRE16_LIM = 6'h0f;   // 1:16
    localparam logic [PWTB_DIV_W-1:0] PWTB_PRE64_LIM = 6'h3f;   // 1:64

    // ------------------------------------------------------------------
    // period byte layout
    // ------------------------------------------------------------------
    localparam int unsigned PWTB_PER_HI_LSB = 8;
    localparam int unsigned PWTB_PER_HI_W   = 4;
    localparam logic [PWTB_CNT_W-1:0] PWTB_CNT_ZERO = 12'h000;
    localparam logic [PWTB_CNT_W-1:0] PWTB_CNT_ONE  = 12'h001;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PWTB_MODE_FREE,
        PWTB_MODE_SINGLE,
        PWTB_MODE_UPDOWN,
        PWTB_MODE_UPDOWN_ALT
    } pwtb_mode_e;

    // contents of the two time-base control registers
    typedef struct packed {
        logic [3:0] postscale_select;
        logic [1:0] prescale_select;
        pwtb_mode_e timebase_mode_select;
    } pwtb_ctl_s;

    localparam pwtb_ctl_s PWTB_CTL_RST = '0;

    // prescale select to divider terminal count
    function automatic logic [PWTB_DIV_W-1:0] pwtb_pre_lim(input logic [1:0] sel);
        case (sel)
            2'h0:    pwtb_pre_lim = PWTB_PRE1_LIM;
            2'h1:    pwtb_pre_lim = PWTB_PRE4_LIM;
            2'h2:    pwtb_pre_lim = PWTB_PRE16_LIM;
            default: pwtb_pre_lim = PWTB_PRE64_LIM;
        endcase
    endfunction : pwtb_pre_lim

endpackage : pwtb_pkg

`default_nettype wire

/* File: verification/pwtb_switch.sv */
// pwtb_switch: power switch load model that times the on-phase of switch 0
`default_nettype none

module pwtb_switch (
    // clock
    input  wire logic                          core_clk_i,
    // gate drive from the pins
    input  wire logic [pwtb_pkg::PWTB_NCH-1:0] gate_i,
    // observed pulses
    output logic [15:0]                        width_o,
    output logic [7:0]                         pulses_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import pwtb_pkg::*;

    logic [15:0] on_q = 16'h0000;

    initial width_o = 16'h0000;
    initial pulses_o = 8'h00;

    // a switch only reports a pulse once its gate falls, so a stuck pin never counts
    always @(posedge core_clk_i) begin
        if (gate_i[0] === 1'b1) begin
            on_q <= on_q + 16'h0001;
        end else if (on_q != 16'h0000) begin
            width_o  <= on_q;
            pulses_o <= pulses_o + 8'h01;
            on_q     <= 16'h0000;
        end
    end
endmodule : pwtb_switch

`default_nettype wire

/* File: verification/tb.sv */
// tb: self-checking bench of the pwm time base
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pwtb_pkg::*;

    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic ctl_wr = 1'b0, run_set = 1'b0, run_clr = 1'b0;
    logic cnt_wr = 1'b0, plo = 1'b0, phi = 1'b0;
    pwtb_ctl_s ctl = PWTB_CTL_RST;
    logic [PWTB_CNT_W-1:0] cnt_d = 12'h000;
    logic [7:0] pb = 8'h00;
    logic [PWTB_NCH-1:0][PWTB_CNT_W-1:0] duty = '0;
    logic [PWTB_NCH-1:0] ovm = 6'h3f, ovl = 6'h00;
    logic [PWTB_CNT_W-1:0] cnt_o, per_o;
    logic run_o, dir_o, irq_o;
    logic [PWTB_NCH-1:0] pwm;
    logic [15:0] width;
    logic [7:0] pulses;
    int n_mismatch = 0, tests_run = 0, n_irq = 0, n, c;
    int n_down = 0;
    int unsigned p, pre, post, d;

    pwtb_timebase i_dut (.core_clk_i(core_clk), .resetn_i(resetn), .ctl_wr_i(ctl_wr), .ctl_i(ctl),
        .run_set_i(run_set), .run_clr_i(run_clr), .cnt_wr_i(cnt_wr), .cnt_data_i(cnt_d),
        .per_lo_wr_i(plo), .per_hi_wr_i(phi), .per_byte_i(pb), .duty_value_i(duty),
        .override_enable_mask_i(ovm), .override_level_select_i(ovl), .timebase_counter_o(cnt_o),
        .period_value_o(per_o), .timebase_run_bit_o(run_o), .count_direction_flag_o(dir_o),
        .timebase_irq_o(irq_o), .pwm_o(pwm));
    pwtb_switch i_sw (.core_clk_i(core_clk), .gate_i(pwm), .width_o(width), .pulses_o(pulses));

    always #5 core_clk = ~core_clk;
    // event tallies, sampled where the registered outputs have settled
    always @(negedge core_clk) begin
        if (irq_o === 1'b1) n_irq++;
        if (dir_o === 1'b1) n_down++;
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk
    task automatic rng(input string nm, input int lo, input int hi, input int g);
        chk(nm, 1, (g >= lo && g <= hi));
    endtask : rng
    // one-cycle strobe: 0 ctl, 1 count, 2 low byte, 3 high byte, 4 run set, 5 run clear
    task automatic hit(input int k);
        @(negedge core_clk);
        {run_clr, run_set, phi, plo, cnt_wr, ctl_wr} = 6'h01 << k;
        @(negedge core_clk);
        {run_clr, run_set, phi, plo, cnt_wr, ctl_wr} = 6'h00;
    endtask : hit
    task automatic set_ctl(input int m, input int pr, input int ps);
        ctl.timebase_mode_select = pwtb_mode_e'(m);
        ctl.prescale_select = 2'(pr);
        ctl.postscale_select = 4'(ps);
        hit(0);
    endtask : set_ctl
    // upper nibble of the high byte is random junk that must be dropped
    task automatic wr_per(input logic [11:0] v);
        pb = v[7:0];
        hit(2);
        pb = {4'($urandom), v[11:8]};
        hit(3);
        @(negedge core_clk);
    endtask : wr_per
    task automatic wait_irq(output int w);
        w = 0;
        do begin
            @(negedge core_clk);
            w++;
        end while (irq_o !== 1'b1 && w < 20000);
        if (w >= 20000) n_mismatch++;
    endtask : wait_irq
    function automatic int free_gap(int unsigned pv, int unsigned pr, int unsigned ps);
        return (pv + 1) * (1 << (2 * pr)) * 4 * (ps + 1);
    endfunction : free_gap
    task automatic conclude();
        $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude

    // watchdog sized well above the longest sequence
    initial begin
        #1ms;
        n_mismatch++;
        conclude();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h3425));
        repeat (5) @(negedge core_clk);
        resetn = 1'b1;
        @(negedge core_clk);
        chk("reset", 0, {cnt_o, per_o, run_o, pwm});
        $display("test reset done");
        // free running, random and corner settings
        for (int i = 0; i < 5; i++) begin
            p = (i == 4) ? 1 : 1 + $urandom_range(6);
            pre = (i == 4) ? 3 : $urandom_range(2);
            post = (i == 4) ? 15 : $urandom_range(3);
            hit(5);
            wr_per(12'(p));
            chk("per_stopped", p, per_o);
            set_ctl(0, pre, post);
            hit(4);
            wait_irq(n);
            wait_irq(n);
            chk("free_gap", free_gap(p, pre, post), n);
            chk("run_kept", 1, run_o);
        end
        $display("test free done");
        // counter write, control write and prescaler clear
        hit(5);
        wr_per(12'hfff);
        set_ctl(0, 3, 0);
        hit(4);
        cnt_d = 12'($urandom) & 12'h7ff;
        hit(1);
        chk("cnt_wr", cnt_d, cnt_o);
        for (n = 0; cnt_o === cnt_d && n < 400; n++) @(negedge core_clk);
        rng("pre_clr_cnt", 248, 260, n);
        c = cnt_o;
        hit(0);
        chk("ctl_keeps_cnt", c, cnt_o);
        for (n = 0; cnt_o === 12'(c) && n < 400; n++) @(negedge core_clk);
        rng("pre_clr_ctl", 248, 260, n);
        $display("test prescale done");
        // up/down codes, direction and zero-time period load
        for (int m = 2; m < 4; m++) begin
            hit(5);
            wr_per(12'h005);
            set_ctl(m, 0, 0);
            hit(4);
            wait_irq(n);
            c = n_down;
            wait_irq(n);
            chk("ud_gap", 40, n);
            // down leg of a period of 5 lasts five ticks of four cycles
            rng("dir_down", 19, 21, n_down - c);
            wr_per(12'h006);
            wait_irq(n);
            wait_irq(n);
            chk("ud_reload", 48, n);
            chk("ud_per", 6, per_o);
        end
        $display("test updown done");
        // single pulse with two overridden pins
        hit(5);
        d = 2 + $urandom_range(3);
        for (int k = 0; k < PWTB_NCH; k++) duty[k] = 12'(d);
        ovm = 6'h0f;
        ovl = 6'h20;
        wr_per(12'h00c);
        // park the counter at zero so the pulse starts from a known count
        cnt_d = 12'h000;
        hit(1);
        set_ctl(1, 0, 0);
        chk("ovd_idle", 6'h20, pwm);
        for (int k = 0; k < 2; k++) begin
            c = n_irq;
            hit(4);
            repeat (2) @(negedge core_clk);
            chk("pulse_on", 6'h2f, pwm);
            for (n = 0; run_o === 1'b1 && n < 200; n++) @(negedge core_clk);
            repeat (3) @(negedge core_clk);
            chk("pulse_end", {1'b0, 6'h20, 12'h000}, {run_o, pwm, cnt_o});
            chk("irq_once", c + 1, n_irq);
            chk("per_kept", 12'h00c, per_o);
            rng("width", 4 * d - 4, 4 * d + 4, width);
            chk("pulses", k + 1, pulses);
        end
        $display("test single done");
        conclude();
    end
endmodule : tb

`default_nettype wire
